// ===== include/sensor_readout_pkg.sv
// Constants and types shared by the sensor serial readout logic.
package sensor_readout_pkg;
   localparam int unsigned RESULT_W = 16;
   localparam int unsigned SETUP_LEN = 4;
   localparam logic [4:0] START_LEN = 5'h03;
   localparam logic [4:0] SETUP_LAST = 5'h03;
   localparam logic [4:0] STOP_LEN = 5'h03;
   localparam logic [4:0] ACK_CLKS = 5'h02;
   localparam logic [4:0] READ_CLKS = 5'h11;
   localparam int unsigned RESET_LEN = 21;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam logic [4:0] CNT_RESET = 5'h00;
   localparam logic DOUT_RESET = 1'b0;
   localparam logic [3:0] SETUP_PRESSURE_DEF = 4'ha;
   localparam logic [3:0] SETUP_TEMP_DEF = 4'h9;
   localparam logic [3:0] SETUP_CAL_ONE_DEF = 4'h5;
   localparam logic [3:0] SETUP_CAL_TWO_DEF = 4'h6;
   localparam logic [3:0] SETUP_CAL_THREE_DEF = 4'hc;
   localparam logic [3:0] SETUP_CAL_FOUR_DEF = 4'h3;
   localparam logic [4:0] CAL_LEAD_DEF = 5'h00;
   localparam logic [20:0] RESET_PATTERN_DEF = 21'h155540;
   localparam logic [15:0] CAL_WORD_DEF = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STOP = 3'b010,
      ST_ACK = 3'b011,
      ST_CONV = 3'b100,
      ST_READ = 3'b101
   } proto_state_t;

   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_PRESSURE = 3'b001,
      CMD_TEMP = 3'b010,
      CMD_CAL = 3'b011
   } cmd_kind_t;
endpackage

// ===== logic/pressure_sensor_serial_readout.sv
// Serial readout logic of the pressure sensor and its result FIFO.
`timescale 1ns/1ps

module result_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 4
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && (cnt_q != '0);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];

   // Occupancy moves by one on a lone push or a lone pop.
   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         cnt_q <= '0;
         wr_q <= '0;
         rd_q <= '0;
         in_ready_o <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   // Storage has no reset; only written entries are ever read.
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule

module pin_sync #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   // Each pin passes two flip-flops before any logic reads it.
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic hold_q;
      always_ff @(posedge clk_sys_i) begin
         if (reset_i) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
         end else begin
            meta_q <= pin_i[i];
            hold_q <= meta_q;
         end
      end
      assign sync_o[i] = hold_q;
   end
endmodule

module pressure_sensor_serial_readout
   import sensor_readout_pkg::*;
#(
   parameter logic [3:0] SETUP_PRESSURE = SETUP_PRESSURE_DEF,
   parameter logic [3:0] SETUP_TEMP = SETUP_TEMP_DEF,
   parameter logic [3:0] SETUP_CAL_ONE = SETUP_CAL_ONE_DEF,
   parameter logic [3:0] SETUP_CAL_TWO = SETUP_CAL_TWO_DEF,
   parameter logic [3:0] SETUP_CAL_THREE = SETUP_CAL_THREE_DEF,
   parameter logic [3:0] SETUP_CAL_FOUR = SETUP_CAL_FOUR_DEF,
   parameter logic [4:0] CAL_LEAD_CLKS = CAL_LEAD_DEF,
   parameter logic [20:0] RESET_PATTERN = RESET_PATTERN_DEF,
   parameter logic [15:0] CAL_WORD_ONE = CAL_WORD_DEF,
   parameter logic [15:0] CAL_WORD_TWO = CAL_WORD_DEF,
   parameter logic [15:0] CAL_WORD_THREE = CAL_WORD_DEF,
   parameter logic [15:0] CAL_WORD_FOUR = CAL_WORD_DEF
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic din_i,
   output logic dout_o,
   output logic conv_start_o,
   output logic conv_temp_o,
   input wire logic conv_valid_i,
   input wire logic [RESULT_W-1:0] conv_data_i,
   output logic conv_ready_o,
   output logic busy_o
);
   logic sclk_s2_q;
   logic sclk_s3_q;
   logic din_s2_q;
   logic rise;
   logic [RESET_LEN-1:0] hist_q;
   logic reset_seen;
   proto_state_t state_q;
   cmd_kind_t cmd_q;
   logic [4:0] cnt_q;
   logic [4:0] lead_q;
   logic [SETUP_LEN-1:0] setup_q;
   logic [RESULT_W-1:0] shift_q;
   logic [SETUP_LEN-1:0] code;
   logic fifo_valid;
   logic fifo_pop;
   logic [RESULT_W-1:0] fifo_data;

   // Maps a setup code to the kind of command it starts.
   function automatic cmd_kind_t decode_setup(input logic [3:0] c);
      if (c == SETUP_PRESSURE) begin
         return CMD_PRESSURE;
      end else if (c == SETUP_TEMP) begin
         return CMD_TEMP;
      end else if (c == SETUP_CAL_ONE || c == SETUP_CAL_TWO ||
                   c == SETUP_CAL_THREE || c == SETUP_CAL_FOUR) begin
         return CMD_CAL;
      end else begin
         return CMD_NONE;
      end
   endfunction

   // Picks the calibration word that a setup code reads out.
   function automatic logic [15:0] cal_word(input logic [3:0] c);
      if (c == SETUP_CAL_ONE) begin
         return CAL_WORD_ONE;
      end else if (c == SETUP_CAL_TWO) begin
         return CAL_WORD_TWO;
      end else if (c == SETUP_CAL_THREE) begin
         return CAL_WORD_THREE;
      end else begin
         return CAL_WORD_FOUR;
      end
   endfunction

   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i({sclk_i, din_i}),
      .sync_o({sclk_s2_q, din_s2_q})
   );

   // The delayed shift clock gives the rising edge detector.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sclk_s3_q <= 1'b0;
      end else begin
         sclk_s3_q <= sclk_s2_q;
      end
   end

   // Edge detect, and the setup code as it stands after this bit.
   assign rise = sclk_s2_q && !sclk_s3_q;
   assign code = {setup_q[SETUP_LEN-2:0], din_s2_q};
   assign reset_seen = ({hist_q[RESET_LEN-2:0], din_s2_q} == RESET_PATTERN);
   // A reset pattern at the same rise wins, so no result is lost.
   assign fifo_pop = (state_q == ST_CONV) && fifo_valid &&
                     !(rise && reset_seen);

   // Input bit history for the reset pattern, taken at clock rises.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         hist_q <= '0;
      end else if (rise) begin
         hist_q <= {hist_q[RESET_LEN-2:0], din_s2_q};
      end
   end

   // Command framing, acknowledge, conversion wait and readout.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         cmd_q <= CMD_NONE;
         cnt_q <= CNT_RESET;
         lead_q <= CNT_RESET;
         setup_q <= '0;
         shift_q <= '0;
         dout_o <= DOUT_RESET;
         conv_start_o <= 1'b0;
         conv_temp_o <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         if (rise && reset_seen) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_RESET;
            dout_o <= DOUT_RESET;
         end else if (fifo_pop) begin
            shift_q <= fifo_data;
            dout_o <= 1'b0;
            cnt_q <= CNT_RESET;
            lead_q <= CNT_RESET;
            state_q <= ST_READ;
         end else if (rise) begin
            case (state_q)
               ST_IDLE: begin
                  if (din_s2_q) begin
                     if (cnt_q == START_LEN - 5'h01) begin
                        state_q <= ST_SETUP;
                        cnt_q <= CNT_RESET;
                     end else begin
                        cnt_q <= cnt_q + 5'h01;
                     end
                  end else begin
                     cnt_q <= CNT_RESET;
                  end
               end
               ST_SETUP: begin
                  setup_q <= code;
                  if (cnt_q == SETUP_LAST) begin
                     cmd_q <= decode_setup(code);
                     state_q <= ST_STOP;
                     cnt_q <= CNT_RESET;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
               ST_STOP: begin
                  if (din_s2_q || cmd_q == CMD_NONE) begin
                     state_q <= ST_IDLE;
                     cnt_q <= CNT_RESET;
                  end else if (cnt_q == STOP_LEN - 5'h01) begin
                     cnt_q <= CNT_RESET;
                     if (cmd_q == CMD_CAL) begin
                        shift_q <= cal_word(setup_q);
                        lead_q <= CAL_LEAD_CLKS;
                        state_q <= ST_READ;
                     end else begin
                        dout_o <= 1'b1;
                        conv_temp_o <= (cmd_q == CMD_TEMP);
                        state_q <= ST_ACK;
                     end
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
               ST_ACK: begin
                  if (cnt_q == ACK_CLKS - 5'h01) begin
                     state_q <= ST_CONV;
                     conv_start_o <= 1'b1;
                     cnt_q <= CNT_RESET;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
               ST_READ: begin
                  // Position holds while the clock pauses.
                  if (cnt_q == READ_CLKS + lead_q - 5'h01) begin
                     dout_o <= 1'b0;
                     state_q <= ST_IDLE;
                     cnt_q <= CNT_RESET;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                     if (cnt_q >= lead_q) begin
                        dout_o <= shift_q[RESULT_W-1];
                        shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
                     end
                  end
               end
               ST_CONV: begin
                  // Clock rises during a conversion act only through the reset pattern.
                  cnt_q <= CNT_RESET;
               end
               default: begin
                  cnt_q <= cnt_q;
               end
            endcase
         end
      end
   end

   // Busy lags the state by one cycle but comes from a flip-flop.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= (state_q != ST_IDLE);
      end
   end

   result_fifo #(
      .WIDTH(RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .in_valid_i(conv_valid_i),
      .in_ready_o(conv_ready_o),
      .in_data_i(conv_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );
endmodule

// ===== tb/pressure_sensor_serial_readout_asserts.sv
// Port checks for the sensor serial readout, attached by bind.
`timescale 1ns/1ps
module readout_asserts
   import sensor_readout_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic dout_o,
   input wire logic conv_start_o,
   input wire logic conv_temp_o,
   input wire logic conv_valid_i,
   input wire logic [RESULT_W-1:0] conv_data_i,
   input wire logic conv_ready_o,
   input wire logic busy_o
);
   localparam int LIM = 8;
   logic sclk_q;
   logic [4:0] since_rise_q;
   logic pend_q;
   always_ff @(posedge clk_sys_i) begin
      sclk_q <= sclk_i;
      if (reset_i) since_rise_q <= 5'h1f;
      else if (sclk_i && !sclk_q) since_rise_q <= 5'h00;
      else if (since_rise_q != 5'h1f) since_rise_q <= since_rise_q + 5'h01;
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !busy_o || $fell(dout_o)) pend_q <= 1'b0;
      else if (conv_start_o) pend_q <= 1'b1;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   AST_DOUT_RISE: assert property ($rose(dout_o) |-> since_rise_q <= LIM)
      else $error("output rose without a shift clock rise");
   AST_START_RISE: assert property (conv_start_o |-> since_rise_q <= LIM)
      else $error("conversion start away from a shift clock rise");
   AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
      else $error("conversion start longer than one cycle");
   AST_START_ACK: assert property (conv_start_o |-> busy_o && dout_o)
      else $error("conversion start without acknowledge");
   AST_IDLE_LOW: assert property (!busy_o |-> !dout_o)
      else $error("output high while idle");
   AST_FIFO_FILL: assert property ($fell(conv_ready_o) |-> $past(conv_valid_i))
      else $error("fifo ready fell without a push");
   AST_COMPLETE: assert property ($fell(dout_o) && since_rise_q > LIM |-> pend_q)
      else $error("output fell with no conversion pending");
   AST_PAUSE_HOLD: assert property (since_rise_q > LIM && !pend_q |-> $stable(dout_o))
      else $error("output moved while the shift clock paused");
   AST_BUSY_FRAME: assert property ($rose(busy_o) |-> since_rise_q <= LIM)
      else $error("busy rose without host clocking");
   COV_PRESSURE: cover property (conv_start_o && !conv_temp_o);
   COV_TEMP: cover property (conv_start_o && conv_temp_o);
   COV_FULL: cover property ($fell(conv_ready_o));
endmodule
bind pressure_sensor_serial_readout readout_asserts u_asserts (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk_i), .din_i(din_i),
   .dout_o(dout_o), .conv_start_o(conv_start_o), .conv_temp_o(conv_temp_o),
   .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
   .conv_ready_o(conv_ready_o), .busy_o(busy_o)
);

// ===== tb/sensor_host_model.sv
// Host model that clocks the three-wire link and collects output bits.
`timescale 1ns/1ps
module sensor_host_model (
   input wire logic clk_sys_i,
   output logic sclk_o,
   output logic din_o,
   input wire logic dout_i
);
   logic [31:0] rx_bits;
   initial begin
      sclk_o = 1'b0;
      din_o = 1'b0;
      rx_bits = 32'h0;
   end
   // Sends n bits first bit highest; the clock stands low between calls.
   task automatic xfer(input logic [31:0] bits, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         din_o = bits[i];
         repeat (4) @(negedge clk_sys_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge clk_sys_i);
         rx_bits = {rx_bits[30:0], dout_i};
         sclk_o = 1'b0;
      end
   endtask
endmodule

// ===== tb/pressure_sensor_serial_readout_tb.sv
// Self-checking bench for the sensor serial readout.
`timescale 1ns/1ps
module pressure_sensor_serial_readout_tb
   import sensor_readout_pkg::*;
;
   localparam logic [63:0] CAL_ALL = 64'ha5c3_5a3c_0ff0_f00f;
   localparam logic [15:0] CAL_CODES = {SETUP_CAL_ONE_DEF, SETUP_CAL_TWO_DEF,
      SETUP_CAL_THREE_DEF, SETUP_CAL_FOUR_DEF};
   logic clk, rst, sclk, din, dout, conv_start, conv_temp;
   logic conv_valid, conv_ready, busy, last_temp;
   logic [15:0] conv_data;
   int miscompares, n_checks, n_starts;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   pressure_sensor_serial_readout #(
      .CAL_WORD_ONE(CAL_ALL[63:48]), .CAL_WORD_TWO(CAL_ALL[47:32]),
      .CAL_WORD_THREE(CAL_ALL[31:16]), .CAL_WORD_FOUR(CAL_ALL[15:0])
   ) DUT (
      .clk_sys_i(clk), .reset_i(rst), .sclk_i(sclk), .din_i(din),
      .dout_o(dout), .conv_start_o(conv_start), .conv_temp_o(conv_temp),
      .conv_valid_i(conv_valid), .conv_data_i(conv_data),
      .conv_ready_o(conv_ready), .busy_o(busy)
   );
   sensor_host_model host (
      .clk_sys_i(clk), .sclk_o(sclk), .din_o(din), .dout_i(dout)
   );
   always @(posedge clk) begin
      if (conv_start) begin
         n_starts++;
         last_temp = conv_temp;
      end
   end
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic idle_check(input string msg);
      repeat (4) @(negedge clk);
      check(busy === 1'b0 && dout === 1'b0, msg);
   endtask
   task automatic read_cal();
      for (int i = 0; i < 4; i++) begin
         host.xfer({3'b111, CAL_CODES[15-4*i -: 4], 20'h0}, 27);
         check(host.rx_bits[16:1] === CAL_ALL[63-16*i -: 16], "cal word");
         idle_check("not idle after calibration read");
      end
   endtask
   task automatic convert(input logic temp, input logic supply,
      input logic [15:0] data, input int pause);
      int s;
      int k;
      s = n_starts;
      host.xfer({3'b111, temp ? SETUP_TEMP_DEF : SETUP_PRESSURE_DEF, 3'b000}, 10);
      check(host.rx_bits[0] === 1'b1, "no acknowledge");
      host.xfer(32'h0, 2);
      repeat (4) @(negedge clk);
      check(n_starts == s + 1 && last_temp === temp, "conversion start");
      if (supply) begin
         repeat (20) @(negedge clk);
         check(dout === 1'b1 && conv_ready === 1'b1, "early completion");
         conv_data = data;
         conv_valid = 1'b1;
         @(negedge clk);
         conv_valid = 1'b0;
      end
      k = 0;
      while (dout !== 1'b0 && k < 400) begin
         @(negedge clk);
         k++;
      end
      check(dout === 1'b0, "completion missing");
      if (dout !== 1'b0) end_of_test();
      host.xfer(32'h0, pause);
      repeat (40) @(negedge clk);
      host.xfer(32'h0, 17 - pause);
      check(host.rx_bits[16:1] === data, "conversion result");
      idle_check("not idle after result");
   endtask
   task automatic refuse();
      host.xfer({3'b111, 4'h0, 3'b000}, 10);
      idle_check("unknown setup accepted");
   endtask
   task automatic reset_mid();
      host.xfer({3'b111, SETUP_PRESSURE_DEF, 5'h00}, 12);
      repeat (8) @(negedge clk);
      check(busy === 1'b1 && dout === 1'b1, "not converting");
      host.xfer({11'h0, RESET_PATTERN_DEF}, 21);
      idle_check("reset pattern ignored");
   endtask
   task automatic fill_drain();
      for (int i = 0; i < 5; i++) begin
         check(conv_ready === (i < 4), "fifo ready");
         conv_data = 16'h1000 + 16'(i);
         conv_valid = 1'b1;
         @(negedge clk);
      end
      conv_valid = 1'b0;
      for (int i = 0; i < 4; i++) convert(i[0], 1'b0, 16'h1000 + 16'(i), 0);
      check(conv_ready === 1'b1, "fifo not drained");
   endtask
   initial begin
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_data = 16'h0;
      miscompares = 0;
      n_checks = 0;
      n_starts = 0;
      last_temp = 1'b0;
      repeat (4) @(negedge clk);
      check(dout === 1'b0 && busy === 1'b0 && conv_ready === 1'b1, "reset");
      rst = 1'b0;
      @(negedge clk);
      read_cal();
      convert(1'b0, 1'b1, 16'h8001, 8);
      convert(1'b1, 1'b1, 16'h7ffe, 0);
      refuse();
      reset_mid();
      fill_drain();
      end_of_test();
   end
endmodule
